// ### wdt_top.sv
// Watchdog timer with shared postscaler, AXI4-Lite registers and interrupt
//
// Function
// - The counter advances on ticks of its own oscillator and keeps counting while asleep.
// - An expiry during normal execution raises a device reset marked as a watchdog reset.
// - An expiry during sleep wakes the core without a reset.
// - Every expiry drives the time-out status flag to zero.
// - A zero enable fuse at bit 2 of the configuration word disables the watchdog for good.
// - One shared stage serves as timer prescaler or watchdog postscaler per bit 3 of the option register.
// - Kick and sleep instructions zero the counter and, when assigned, the postscaler.
// - A kick clears the shared stage count only when it serves the watchdog and leaves the assignment as it is.
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "wdt_defs.svh"
`default_nettype none
module wdt_top
    import wdt_pkg::*;
#(
    parameter int BASE_BITS = 8,
    parameter int RATIO_BITS = 3
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic osc_tick,
    input wire logic [7:0] fuse_word,
    input wire logic kick_instruction,
    input wire logic sleep_instruction,
    input wire logic other_wake,
    input wire logic timer_src_tick,
    output logic timer_prescaled_tick,
    output logic device_reset_req,
    output logic reset_was_watchdog,
    output logic wake_req,
    output logic asleep,
    output logic timeout_status_flag,
    output logic irq,
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int PCW = (2**RATIO_BITS) - 1;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (BASE_BITS < 1 || BASE_BITS > 16)
    begin : g_chk_base
        $error("wdt_top: BASE_BITS must be 1 to 16");
    end
    if (RATIO_BITS != 3)
    begin : g_chk_ratio
        $error("wdt_top: the ratio field is three bits wide");
    end

    // Address decode shared by the read and the write paths
    function automatic wdt_reg_type reg_decode(input logic [15:0] addr);
        if (addr == `WDT_ADDR_OPTION)
            return reg_option;
        else if (addr == `WDT_ADDR_CONFIG)
            return reg_config;
        else if (addr == `WDT_ADDR_STATUS)
            return reg_status;
        else if (addr == `WDT_ADDR_MASK)
            return reg_mask;
        else if (addr == `WDT_ADDR_STATE)
            return reg_state;
        else
            return reg_none;
    endfunction

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [7:0] timer_prescale_config;
    logic [7:0] device_configuration_word;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [BASE_BITS-1:0] base_count;
    logic [PCW-1:0] post_count;
    wdt_state_type state;
    logic aw_held;
    logic w_held;
    logic [15:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;

    // ------------------------------------------------------------------------
    // Watchdog datapath
    // ------------------------------------------------------------------------
    logic watchdog_enable_fuse;
    logic prescaler_assign_select;
    logic [2:0] prescale_ratio_field;
    logic clear_req;
    logic base_wrap;
    logic post_in;
    logic post_out;
    logic post_clear;
    logic expiry;
    logic assign_change;

    // Fuse and option fields
    assign watchdog_enable_fuse = device_configuration_word[`WDT_FUSE_EN_BIT];
    assign prescaler_assign_select = timer_prescale_config[`WDT_PSA_BIT];
    assign prescale_ratio_field = timer_prescale_config[`WDT_RATIO_MSB:`WDT_RATIO_LSB];

    // Kick or sleep restarts the count; the core clock halting does not stop the oscillator
    assign clear_req = kick_instruction || sleep_instruction;
    assign base_wrap = watchdog_enable_fuse && osc_tick && (base_count == '1);

    // One shared stage: watchdog postscaler or timer prescaler, never both
    assign post_in = prescaler_assign_select ? base_wrap : timer_src_tick;
    assign timer_prescaled_tick = !prescaler_assign_select && post_out;
    assign expiry = prescaler_assign_select ? post_out : base_wrap;

    // A kick clears the stage only when it serves the watchdog; a timer count survives
    assign post_clear = (clear_req && prescaler_assign_select) || assign_change;

    wdt_postscaler #(
        .RATIO_BITS(RATIO_BITS)
    ) u_post (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .in_tick(post_in),
        .clear(post_clear),
        .ratio(prescale_ratio_field),
        .out_tick(post_out),
        .count(post_count)
    );

    // Base counter runs on oscillator ticks in both run and sleep
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !watchdog_enable_fuse)
            base_count <= '0;
        else if (ce)
        begin
            if (clear_req)
                base_count <= '0;
            else if (osc_tick)
                base_count <= base_count + BASE_BITS'(1);
        end
    end

    // ------------------------------------------------------------------------
    // Run/sleep state, reset and wake requests
    // ------------------------------------------------------------------------
    wdt_state_type next_state;
    logic expire_run;
    logic expire_sleep;
    assign expire_run = expiry && (state == st_run);
    assign expire_sleep = expiry && (state == st_asleep);

    always_comb
    begin
        next_state = state;
        case (state)
            st_run:
                if (sleep_instruction && !expiry)
                    next_state = st_asleep;
            st_asleep:
                if (expiry || other_wake)
                    next_state = st_run;
            default:
                next_state = st_run;
        endcase
    end

    // Requests are one-cycle pulses; the cause bit stays until power-on reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= st_run;
            device_reset_req <= 1'b0;
            wake_req <= 1'b0;
            reset_was_watchdog <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            device_reset_req <= expire_run;
            wake_req <= expire_sleep;
            if (expire_run)
                reset_was_watchdog <= 1'b1;
        end
    end
    assign asleep = (state == st_asleep);

    // Expiry wins over a kick in the same cycle, so a real time-out is never hidden
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timeout_status_flag <= 1'b1;
        else if (ce)
        begin
            if (expiry)
                timeout_status_flag <= 1'b0;
            else if (clear_req)
                timeout_status_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------------
    wdt_reg_type wr_sel;
    wdt_reg_type rd_sel;
    logic do_write;
    logic wr_option;
    logic wr_status;
    logic wr_mask;
    logic [31:0] rd_word;

    // Ready only while frozen state can accept; a low clock enable stalls the bus
    assign awready = ce && !aw_held && !bvalid;
    assign wready = ce && !w_held && !bvalid;
    assign arready = ce && !rvalid;
    assign do_write = ce && aw_held && w_held && !bvalid;
    assign wr_sel = reg_decode(aw_addr_q);
    assign rd_sel = reg_decode(araddr);
    assign wr_option = do_write && w_strb_q && (wr_sel == reg_option);
    assign wr_status = do_write && w_strb_q && (wr_sel == reg_status);
    assign wr_mask = do_write && w_strb_q && (wr_sel == reg_mask);
    assign assign_change = wr_option
        && (w_data_q[`WDT_PSA_BIT] != prescaler_assign_select);

    // Read data selection; reserved bits read as zero
    assign rd_word = (rd_sel == reg_option) ? {24'h000000, timer_prescale_config} :
        (rd_sel == reg_config) ? {24'h000000, device_configuration_word} :
        (rd_sel == reg_status) ? {30'h00000000, irq_status} :
        (rd_sel == reg_mask) ? {30'h00000000, irq_mask} :
        (rd_sel == reg_state) ? {5'h00, reset_was_watchdog, asleep, timeout_status_flag,
            1'b0, post_count, {(16 - BASE_BITS){1'b0}}, base_count} :
        32'h00000000;

    // Address and data are taken independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 16'h0000;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data_q <= wdata[7:0];
                w_strb_q <= wstrb[0];
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // Write response follows the write by one cycle; unmapped addresses get DECERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= `WDT_RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                bvalid <= 1'b1;
                bresp <= (wr_sel == reg_none) ? `WDT_RESP_DECERR : `WDT_RESP_OKAY;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    // Read data is registered at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `WDT_RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= (rd_sel == reg_none) ? `WDT_RESP_DECERR : `WDT_RESP_OKAY;
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end

    // Option register steers the shared stage; the kick never touches it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_prescale_config <= `WDT_OPTION_RESET;
        else if (ce && wr_option)
            timer_prescale_config <= w_data_q;
    end

    // Configuration word is non-volatile: latched from the fuse pins in reset, read-only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            device_configuration_word <= fuse_word;
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    logic [1:0] irq_events;
    assign irq_events = {expire_sleep, expire_run};

    // A new event in the cycle of a write-one-to-clear still sets the bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
        end
        else if (ce)
        begin
            irq_status <= (irq_status & ~(wr_status ? w_data_q[1:0] : 2'h0)) | irq_events;
            if (wr_mask)
                irq_mask <= w_data_q[1:0];
        end
    end
    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_osc_counts_asleep: assert property (
        ce && asleep && osc_tick && watchdog_enable_fuse && !clear_req && !base_wrap
        |=> base_count == $past(base_count) + BASE_BITS'(1))
        else $error("counter did not advance on an oscillator tick in sleep");
    a_run_expiry_reset: assert property (
        ce && expiry && !asleep |=> device_reset_req && reset_was_watchdog && !wake_req)
        else $error("expiry in run did not raise a watchdog reset");
    a_sleep_expiry_wake: assert property (
        ce && expiry && asleep |=> wake_req && !device_reset_req && !asleep)
        else $error("expiry in sleep did not wake the core");
    a_expiry_clears_flag: assert property (
        ce && expiry |=> !timeout_status_flag)
        else $error("time-out flag not cleared on expiry");
    a_fuse_off_silent: assert property (
        !watchdog_enable_fuse |-> !expiry && base_count == '0)
        else $error("disabled watchdog still counting");
    a_timer_gets_stage: assert property (
        !prescaler_assign_select && ce && timer_src_tick
        && post_count == PCW'((1 << prescale_ratio_field) - 1) |-> timer_prescaled_tick)
        else $error("timer path lost the shared stage");
    a_kick_zeroes_counts: assert property (
        ce && clear_req && prescaler_assign_select && !wr_option
        |=> base_count == '0 && post_count == PCW'(0))
        else $error("kick or sleep left a count standing");
    a_kick_keeps_assign: assert property (
        ce && kick_instruction && !wr_option
        |=> $stable(prescaler_assign_select) && $stable(prescale_ratio_field))
        else $error("kick changed the prescaler assignment");
    a_ratio_terminal: assert property (
        post_out |-> post_count == PCW'((1 << prescale_ratio_field) - 1))
        else $error("postscaler fired at the wrong count");

    c_reset_event: cover property (ce && expire_run ##1 device_reset_req);
    c_wake_event: cover property (ce && sleep_instruction ##[1:300] wake_req);
    c_kick_assigned: cover property (ce && kick_instruction && prescaler_assign_select
        && post_count != PCW'(0));
    c_irq_raised: cover property (irq);
endmodule // wdt_top
`default_nettype wire

// ### wdt_defs.svh
// Register offsets, field positions and reset values of the watchdog block
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses (byte address is four times the index)
// ----------------------------------------------------------------------------
`define WDT_IDX_OPTION 16'h0081
`define WDT_IDX_CONFIG 16'h2007
`define WDT_IDX_STATUS 16'h0010
`define WDT_IDX_MASK 16'h0011
`define WDT_IDX_STATE 16'h0012
`define WDT_ADDR_OPTION (`WDT_IDX_OPTION << 2)
`define WDT_ADDR_CONFIG (`WDT_IDX_CONFIG << 2)
`define WDT_ADDR_STATUS (`WDT_IDX_STATUS << 2)
`define WDT_ADDR_MASK (`WDT_IDX_MASK << 2)
`define WDT_ADDR_STATE (`WDT_IDX_STATE << 2)

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WDT_FUSE_EN_BIT 2
`define WDT_PSA_BIT 3
`define WDT_RATIO_LSB 0
`define WDT_RATIO_MSB 2
`define WDT_OPTION_RESET 8'h0f
`define WDT_IRQ_RESET_EV 0
`define WDT_IRQ_WAKE_EV 1
`define WDT_STATE_TO_BIT 24
`define WDT_STATE_SLEEP_BIT 25
`define WDT_STATE_CAUSE_BIT 26
`define WDT_RESP_OKAY 2'b00
`define WDT_RESP_DECERR 2'b11

`endif

// ### wdt_pkg.sv
// Types shared by the watchdog block
`default_nettype none
package wdt_pkg;
    // Core execution state as seen by the watchdog
    typedef enum logic {st_run, st_asleep} wdt_state_type;
    // Register selected by a bus address
    typedef enum logic [2:0] {reg_none, reg_option, reg_config, reg_status, reg_mask,
        reg_state} wdt_reg_type;
endpackage
`default_nettype wire

// ### wdt_postscaler.sv
// Shared prescaler / postscaler stage with a power-of-two ratio
`default_nettype none
module wdt_postscaler
    import wdt_pkg::*;
#(
    parameter int RATIO_BITS = 3
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic in_tick,
    input wire logic clear,
    input wire logic [RATIO_BITS-1:0] ratio,
    output logic out_tick,
    output logic [(2**RATIO_BITS)-2:0] count
);
    localparam int CW = (2**RATIO_BITS) - 1;

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    if (RATIO_BITS < 1 || RATIO_BITS > 4)
    begin : g_chk
        $error("wdt_postscaler: RATIO_BITS must be 1 to 4");
    end

    // Terminal count is two to the ratio, minus one
    logic [CW-1:0] limit;
    logic at_limit;
    assign limit = CW'((1 << ratio) - 1);
    assign at_limit = (count == limit);
    assign out_tick = in_tick && at_limit;

    // Count input ticks; clear takes precedence so a kick never lets a tick slip
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count <= '0;
        else if (ce)
        begin
            if (clear || out_tick)
                count <= '0;
            else if (in_tick)
                count <= count + CW'(1);
        end
    end
endmodule // wdt_postscaler
`default_nettype wire

// ### tb_watchdog_timer_with_postscaler.sv
// Self-checking testbench of the watchdog block with its shared postscaler
`include "wdt_defs.svh"
`default_nettype none
module tb_watchdog_timer_with_postscaler
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------
    localparam int BB = 2; // Short base count keeps every expiry within 512 oscillator ticks, about a thousand cycles
    logic aclk, aresetn, osc_tick, kick, sleep_i, timer_src_tick, other_wake;
    logic [7:0] fuse_word;
    logic tpt, dev_rst, rww, wake, asleep, to_flag, irq;
    logic [15:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    int err_count, cmp_count, rst_cnt, wake_cnt, tpt_cnt, seed, r, n, i, rb, wb, tc;
    wdt_top #(.BASE_BITS(BB), .RATIO_BITS(3)) dut (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .osc_tick(osc_tick),
        .fuse_word(fuse_word), .kick_instruction(kick), .sleep_instruction(sleep_i),
        .other_wake(other_wake), .timer_src_tick(timer_src_tick), .timer_prescaled_tick(tpt),
        .device_reset_req(dev_rst), .reset_was_watchdog(rww), .wake_req(wake),
        .asleep(asleep), .timeout_status_flag(to_flag), .irq(irq),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // Clock of 50 ns period
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // Pulse counters, sampled on every rising edge so no one-cycle pulse is missed
    always @(posedge aclk)
    begin
        rst_cnt <= rst_cnt + int'(dev_rst === 1'b1);
        wake_cnt <= wake_cnt + int'(wake === 1'b1);
        tpt_cnt <= tpt_cnt + int'(tpt === 1'b1);
    end
    // ------------------------------------------------------------------
    // Tasks and functions
    // ------------------------------------------------------------------
    // Expected ticks to expiry: base wrap times two to the ratio only when assigned
    function automatic int exp_ticks(input int ratio, input bit assigned);
        return (1 << BB) << (assigned ? ratio : 0);
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic [7:0] f);
        aresetn <= 1'b0;
        fuse_word <= f;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // Write: address and data offered together, each released when taken
    task automatic axw(input logic [15:0] a, input logic [31:0] d);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
    endtask
    task automatic axr(input logic [15:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata;
        rs = rresp;
    endtask
    // Pulses on the oscillator tick (t=0) or on the timer source (t=1)
    task automatic ticks(input int cnt, input bit t);
        repeat (cnt)
        begin
            osc_tick <= !t;
            timer_src_tick <= t;
            @(posedge aclk);
            osc_tick <= 1'b0;
            timer_src_tick <= 1'b0;
            @(posedge aclk);
        end
        repeat (3) @(posedge aclk);
    endtask
    task automatic pulse_core(input bit is_sleep);
        kick <= !is_sleep;
        sleep_i <= is_sleep;
        @(posedge aclk);
        kick <= 1'b0;
        sleep_i <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        // The full run needs some 5000 cycles; allow about four times that
        #1_000_000;
        err_count++;
        end_sim();
    end
    initial
    begin
        {aresetn, osc_tick, kick, sleep_i, timer_src_tick} = '0;
        {awvalid, wvalid, arvalid, other_wake, awaddr, araddr, wdata} = '0;
        // Response channels stay ready, so no ready is dropped and raised in one step
        {bready, rready} = 2'b11;
        {err_count, cmp_count, rst_cnt, wake_cnt, tpt_cnt} = '0;
        seed = 37542;
        fuse_word = 8'h00;
        do_reset(8'($random(seed)) | 8'h04);
        axr(`WDT_ADDR_OPTION);
        chk("option reset", 32'h0000000f, rd);
        axr(`WDT_ADDR_CONFIG);
        chk("config word", {24'h0, fuse_word}, rd);
        chk("flag reset", 1, to_flag);
        chk("cause reset", 0, rww);
        axr(16'h0300);
        chk("unmapped resp", 3, rs);
        chk("unmapped data", 0, rd);
        axw(16'h0300, 32'h00000001);
        chk("unmapped write resp", 3, rs);
        axw(`WDT_ADDR_MASK, 32'h00000003);
        chk("mask write resp", 0, rs);
        // First pass uses the largest ratio, later passes a random small one
        for (i = 0; i < 3; i++)
        begin
            r = (i == 0) ? 7 : int'($unsigned($random(seed)) % 3);
            rb = rst_cnt;
            wb = wake_cnt;
            axw(`WDT_ADDR_OPTION, 32'h8 | r);
            n = exp_ticks(r, 1);
            // Kick just before expiry restarts the whole count
            pulse_core(0);
            ticks(n - 1, 0);
            pulse_core(0);
            chk("flag after kick", 1, to_flag);
            ticks(n - 1, 0);
            chk("no reset after kick", rb, rst_cnt);
            axr(`WDT_ADDR_OPTION);
            chk("assign kept", 32'h8 | r, rd);
            ticks(1, 0);
            chk("reset count", rb + 1, rst_cnt);
            chk("flag cleared", 0, to_flag);
            chk("cause set", 1, rww);
            chk("irq raised", 1, irq);
            axw(`WDT_ADDR_MASK, 32'h0);
            chk("irq masked", 0, irq);
            axw(`WDT_ADDR_MASK, 32'h3);
            axr(`WDT_ADDR_STATUS);
            chk("status reset bit", 1, rd[0]);
            axw(`WDT_ADDR_STATUS, 32'h3);
            chk("irq cleared", 0, irq);
            // Expiry in sleep wakes the core without a reset
            pulse_core(1);
            chk("asleep", 1, asleep);
            ticks(n, 0);
            chk("wake count", wb + 1, wake_cnt);
            chk("no reset in sleep", rb + 1, rst_cnt);
            chk("awake", 0, asleep);
            chk("flag after wake", 0, to_flag);
            axw(`WDT_ADDR_STATUS, 32'h3);
            // Stage given to the timer: watchdog uses the base count alone
            axw(`WDT_ADDR_OPTION, r);
            tc = tpt_cnt;
            ticks(exp_ticks(r, 1), 1);
            chk("timer ticks", 1 << BB, tpt_cnt - tc);
            pulse_core(0);
            ticks(exp_ticks(r, 0), 0);
            chk("base expiry", rb + 2, rst_cnt);
            axw(`WDT_ADDR_STATUS, 32'h3);
        end
        // Fuse cleared: no expiry even on the short direct path
        n = rst_cnt;
        do_reset(8'($random(seed)) & 8'hfb);
        chk("cause cleared", 0, rww);
        axw(`WDT_ADDR_OPTION, 32'h0);
        ticks(64, 0);
        chk("fuse off reset", n, rst_cnt);
        chk("fuse off flag", 1, to_flag);
        // A wake from another source leaves sleep with no watchdog wake pulse
        n = wake_cnt;
        pulse_core(1);
        chk("asleep again", 1, asleep);
        other_wake <= 1'b1;
        @(posedge aclk);
        other_wake <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("other wake", 0, asleep);
        chk("no watchdog wake", n, wake_cnt);
        end_sim();
    end
endmodule // tb_watchdog_timer_with_postscaler
`default_nettype wire
